// [design/cip_port.sv]
// cip_port: two-wire serial target port of the charger, top level
// assumes open-drain pads resolve the wires outside; scl/sda are async
`timescale 1ns/10ps
module cip_port
  import cip_pkg::*;
(
  input  wire logic        i_clk,                    // 125 MHz clock
  input  wire logic        i_rstn,                   // async, active low
  input  wire logic        i_scl,                    // clock wire level
  output logic             o_scl_out,                // always low
  output logic             o_scl_oe,                 // stretch clock
  input  wire logic        i_sda,                    // data wire level
  output logic             o_sda_out,                // always low
  output logic             o_sda_oe,                 // pull data low
  input  wire logic        i_source_select,          // strap pin
  input  wire logic        i_host_port_level,        // strap pin
  input  wire logic [7:0]  i_charger_status,         // read at index 8
  input  wire logic [6:0]  i_fault_now,              // present faults
  output logic             o_input_highz_enable,     // control field
  output logic      [3:0]  o_input_voltage_floor,    // control field
  output logic      [2:0]  o_input_current_cap,      // control field
  output logic             o_reverse_boost_enable,   // control field
  output logic             o_charging_enable,        // after override
  output logic      [2:0]  o_minimum_system_voltage, // control field
  output logic             o_boost_current_cap,      // control field
  output logic             o_watchdog_kick,          // one-cycle pulse
  output logic             o_default_mode,           // autonomous mode
  output logic      [47:0] o_config_regs,            // indices 7..2
  output logic             o_bus_busy                // START seen
);

  typedef struct packed {
    cip_state_t st;
    cip_state_t after;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic [7:0] idx;
    logic [7:0] widx;
    logic [7:0] wdata;
    logic       byte_done;
    logic       mack;
    logic       busy;
    logic [5:0] hold;
    logic       sda_oe;
    logic       scl_q;
    logic       sda_q;
    logic       wr_stb;
    logic       wcmd;
  } cip_port_t;

  localparam cip_port_t PORT_RST = '{st: S_IDLE, after: S_IDLE,
                                     scl_q: 1'b1, sda_q: 1'b1,
                                     default: '0};

  cip_port_t  pt_reg;
  cip_port_t  pt_next;
  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start;
  logic       stop;
  logic       sda_want;
  logic [7:0] rd_data;

  cip_sync #(.WIDTH(2), .RST_VAL(2'h3)) u_pin_sync (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_d    ({i_scl, i_sda}),
    .o_q    ({scl_s, sda_s})
  );

  // wire edges seen after the synchroniser; 8 ns sampling is far
  // finer than the fast-mode clock, so no spike filter is needed
  assign scl_rise = scl_s & ~pt_reg.scl_q;
  assign scl_fall = ~scl_s & pt_reg.scl_q;
  assign start = scl_s & pt_reg.scl_q & pt_reg.sda_q & ~sda_s;
  assign stop  = scl_s & pt_reg.scl_q & ~pt_reg.sda_q & sda_s;

  // pull low for an acknowledge or for a zero data bit
  assign sda_want = (pt_reg.st == S_ACK) ||
                    (pt_reg.st == S_RD && !pt_reg.sh[7]);

  always_comb begin
    pt_next = pt_reg;
    pt_next.scl_q = scl_s;
    pt_next.sda_q = sda_s;
    pt_next.wr_stb = 1'b0;
    pt_next.wcmd = 1'b0;
    // drive changes only after a hold time from the falling clock
    if (pt_reg.hold != 6'h00) begin
      pt_next.hold = pt_reg.hold - 6'h01;
    end
    if (scl_fall) begin
      pt_next.hold = HOLD_LOAD;
    end
    if (pt_reg.hold == 6'h01) begin
      pt_next.sda_oe = sda_want;
    end
    unique case (pt_reg.st)
      S_IDLE: begin
        pt_next.byte_done = 1'b0;
      end
      S_ADDR, S_IDX, S_WDATA: begin
        if (scl_rise) begin
          pt_next.sh = {pt_reg.sh[6:0], sda_s};
          pt_next.cnt = pt_reg.cnt + 3'h1;
          pt_next.byte_done = (pt_reg.cnt == 3'h7);
        end
        if (scl_fall && pt_reg.byte_done) begin
          pt_next.byte_done = 1'b0;
          pt_next.cnt = 3'h0;
          pt_next.st = S_IDLE;
          if (pt_reg.st == S_ADDR) begin
            if (pt_reg.sh[7:1] == TARGET_ADDR) begin
              pt_next.st = S_ACK;
              pt_next.after = pt_reg.sh[0] ? S_LOAD : S_IDX;
              pt_next.wcmd = ~pt_reg.sh[0];
            end
          end else if (pt_reg.st == S_IDX) begin
            if (pt_reg.sh <= IDX_LAST) begin
              pt_next.idx = pt_reg.sh;
              pt_next.st = S_ACK;
              pt_next.after = S_WDATA;
            end
          end else if (pt_reg.idx <= IDX_RW_LAST) begin
            pt_next.wr_stb = 1'b1;
            pt_next.widx = pt_reg.idx;
            pt_next.wdata = pt_reg.sh;
            pt_next.idx = pt_reg.idx + 8'h01;
            pt_next.st = S_ACK;
            pt_next.after = S_WDATA;
          end
        end
      end
      S_ACK: begin
        if (scl_fall) begin
          pt_next.st = pt_reg.after;
          pt_next.cnt = 3'h0;
        end
      end
      S_LOAD: begin
        // clock held low here while the byte is fetched
        pt_next.sh = rd_data;
        pt_next.cnt = 3'h0;
        pt_next.st = S_RD;
      end
      S_RD: begin
        pt_next.mack = 1'b0;
        if (scl_fall) begin
          pt_next.sh = {pt_reg.sh[6:0], 1'b0};
          pt_next.cnt = pt_reg.cnt + 3'h1;
          if (pt_reg.cnt == 3'h7) begin
            pt_next.st = S_MACK;
          end
        end
      end
      S_MACK: begin
        if (scl_rise) begin
          pt_next.mack = ~sda_s;
        end
        if (scl_fall) begin
          pt_next.st = S_IDLE;
          if (pt_reg.mack && pt_reg.idx < IDX_MULTI_LAST) begin
            pt_next.idx = pt_reg.idx + 8'h01;
            pt_next.st = S_LOAD;
          end
        end
      end
      default: begin
        pt_next.st = S_IDLE;
      end
    endcase
    if (start) begin
      pt_next.busy = 1'b1;
      pt_next.st = S_ADDR;
      pt_next.cnt = 3'h0;
      pt_next.byte_done = 1'b0;
      pt_next.sda_oe = 1'b0;
      pt_next.hold = 6'h00;
    end
    if (stop) begin
      pt_next.busy = 1'b0;
      pt_next.st = S_IDLE;
      pt_next.sda_oe = 1'b0;
      pt_next.hold = 6'h00;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pt_reg <= PORT_RST;
    end else begin
      pt_reg <= pt_next;
    end
  end

  cip_regs u_regs (
    .i_clk                    (i_clk),
    .i_rstn                   (i_rstn),
    .i_wr_stb                 (pt_reg.wr_stb),
    .i_wr_idx                 (pt_reg.widx),
    .i_wr_data                (pt_reg.wdata),
    .i_rd_req                 (pt_reg.st == S_LOAD),
    .i_rd_idx                 (pt_reg.idx),
    .o_rd_data                (rd_data),
    .i_write_cmd              (pt_reg.wcmd),
    .i_source_select          (i_source_select),
    .i_host_port_level        (i_host_port_level),
    .i_charger_status         (i_charger_status),
    .i_fault_now              (i_fault_now),
    .o_input_highz_enable     (o_input_highz_enable),
    .o_input_voltage_floor    (o_input_voltage_floor),
    .o_input_current_cap      (o_input_current_cap),
    .o_reverse_boost_enable   (o_reverse_boost_enable),
    .o_charging_enable        (o_charging_enable),
    .o_minimum_system_voltage (o_minimum_system_voltage),
    .o_boost_current_cap      (o_boost_current_cap),
    .o_watchdog_kick          (o_watchdog_kick),
    .o_default_mode           (o_default_mode),
    .o_config_regs            (o_config_regs)
  );

  // open-drain pins: only the enables move
  assign o_scl_out  = 1'b0;
  assign o_sda_out  = 1'b0;
  assign o_scl_oe   = (pt_reg.st == S_LOAD);
  assign o_sda_oe   = pt_reg.sda_oe;
  assign o_bus_busy = pt_reg.busy;

  localparam int ACK_WAIT = 40;

  default clocking cb_port @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  sequence s_addr_hit;
    pt_reg.st == S_ADDR && pt_reg.byte_done && scl_fall &&
    pt_reg.sh[7:1] == TARGET_ADDR;
  endsequence

  sequence s_addr_miss;
    pt_reg.st == S_ADDR && pt_reg.byte_done && scl_fall &&
    pt_reg.sh[7:1] != TARGET_ADDR;
  endsequence

  sequence s_read_end;
    pt_reg.st == S_MACK && scl_fall &&
    (!pt_reg.mack || pt_reg.idx >= IDX_MULTI_LAST);
  endsequence

  property p_addr_ack;
    s_addr_hit |=> pt_reg.st == S_ACK ##[1:ACK_WAIT] o_sda_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");

  property p_addr_ignore;
    s_addr_miss |=> (pt_reg.st == S_IDLE && !o_sda_oe)[*8];
  endproperty
  a_addr_ignore: assert property (p_addr_ignore)
    else $error("foreign address answered");

  property p_busy_on_start;
    start |=> o_bus_busy && pt_reg.st == S_ADDR;
  endproperty
  a_busy_on_start: assert property (p_busy_on_start)
    else $error("bus not busy after start");

  property p_free_on_stop;
    stop |=> !o_bus_busy && pt_reg.st == S_IDLE && !o_sda_oe;
  endproperty
  a_free_on_stop: assert property (p_free_on_stop)
    else $error("bus not free after stop");

  property p_sda_steady;
    (scl_s && pt_reg.scl_q && !start && !stop) |=> $stable(o_sda_oe);
  endproperty
  a_sda_steady: assert property (p_sda_steady)
    else $error("data drive changed while clock high");

  property p_bad_index;
    (pt_reg.st == S_IDX && pt_reg.byte_done && scl_fall &&
     pt_reg.sh > IDX_LAST) |=> (pt_reg.st == S_IDLE && !o_sda_oe)[*8];
  endproperty
  a_bad_index: assert property (p_bad_index)
    else $error("undefined index acknowledged");

  property p_stretch_short;
    o_scl_oe |-> pt_reg.st == S_LOAD ##1 (!o_scl_oe && pt_reg.st == S_RD);
  endproperty
  a_stretch_short: assert property (p_stretch_short)
    else $error("clock held longer than one fetch");

  property p_read_release;
    s_read_end |=> (pt_reg.st == S_IDLE && !o_sda_oe)[*8];
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("data line held after read ended");

  property p_fault_single;
    (pt_reg.st == S_MACK && scl_fall && pt_reg.idx == IDX_FAULT)
      |=> pt_reg.st == S_IDLE;
  endproperty
  a_fault_single: assert property (p_fault_single)
    else $error("fault register read continued");

  property p_multi_advance;
    (pt_reg.st == S_MACK && scl_fall && pt_reg.mack &&
     pt_reg.idx < IDX_MULTI_LAST)
      |=> pt_reg.st == S_LOAD && pt_reg.idx == $past(pt_reg.idx) + 8'h01;
  endproperty
  a_multi_advance: assert property (p_multi_advance)
    else $error("multi-read index did not advance");

endmodule // cip_port

// [design/cip_pkg.sv]
// cip_pkg: constants, reset values and states of the charger serial port
// shared by the protocol engine and the register file
package cip_pkg;

  localparam logic [6:0] TARGET_ADDR     = 7'h6B;

  localparam logic [7:0] IDX_INPUT_SRC   = 8'h00;
  localparam logic [7:0] IDX_POWER_ON    = 8'h01;
  localparam logic [7:0] IDX_RW_LAST     = 8'h07;
  localparam logic [7:0] IDX_STATUS      = 8'h08;
  localparam logic [7:0] IDX_MULTI_LAST  = 8'h08;
  localparam logic [7:0] IDX_FAULT       = 8'h09;
  localparam logic [7:0] IDX_LAST        = 8'h0A;

  // input_source_control fields
  localparam int HIZ_BIT     = 7;
  localparam int VFLOOR_MSB  = 6;
  localparam int VFLOOR_LSB  = 3;
  localparam int ICAP_MSB    = 2;
  localparam int ICAP_LSB    = 0;
  // power_on_configuration fields
  localparam int REGRST_BIT  = 7;
  localparam int WDKICK_BIT  = 6;
  localparam int RBOOST_BIT  = 5;
  localparam int CHGEN_BIT   = 4;
  localparam int SYSMIN_MSB  = 3;
  localparam int SYSMIN_LSB  = 1;
  localparam int BCAP_BIT    = 0;
  // fault_latch_register: top bit shows default mode
  localparam int DEFMODE_BIT = 7;

  localparam logic [7:0] RST_INPUT_SRC    = 8'h30; // cap bits from straps
  localparam logic [7:0] RST_POWER_ON     = 8'h1B;
  localparam logic [7:0] RST_CHG_CURRENT  = 8'h60;
  localparam logic [7:0] RST_TERM_CURRENT = 8'h11;
  localparam logic [7:0] RST_OTHER        = 8'h00;
  localparam logic [7:0][7:0] RST_RW = {RST_OTHER, RST_OTHER, RST_OTHER,
    RST_OTHER, RST_TERM_CURRENT, RST_CHG_CURRENT, RST_POWER_ON,
    RST_INPUT_SRC};

  localparam logic [2:0] ICAP_SRC_LO     = 3'h7;
  localparam logic [2:0] ICAP_USB_LO     = 3'h0;
  localparam logic [2:0] ICAP_USB_HI     = 3'h2;
  localparam logic [7:0] ID_CODE         = 8'h5A; // arbitrary value
  localparam logic [7:0] READ_UNMAPPED   = 8'hFF;

  // data hold after scl falls, a least time: round up
  localparam int CLK_NS       = 8;
  localparam int SDA_HOLD_NS  = 300;
  localparam int SDA_HOLD_CYC = (SDA_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [5:0] HOLD_LOAD = 6'(SDA_HOLD_CYC);

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000,
    S_ADDR  = 4'b0001,
    S_IDX   = 4'b0010,
    S_WDATA = 4'b0011,
    S_ACK   = 4'b0100,
    S_LOAD  = 4'b0101,
    S_RD    = 4'b0110,
    S_MACK  = 4'b0111
  } cip_state_t;

endpackage

// [design/cip_sync.sv]
// cip_sync: two-flop synchroniser for asynchronous pin levels
// assumes inputs are slow levels; output is valid two edges later
`timescale 1ns/10ps
module cip_sync #(
  parameter int               WIDTH   = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             i_clk,  // system clock
  input  wire logic             i_rstn, // async reset, active low
  input  wire logic [WIDTH-1:0] i_d,    // asynchronous level
  output logic      [WIDTH-1:0] o_q     // synchronised level
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] safe;
  } cip_sync_t;

  cip_sync_t sy_reg;
  cip_sync_t sy_next;

  always_comb begin
    sy_next.meta = i_d;
    sy_next.safe = sy_reg.meta;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sy_reg <= {RST_VAL, RST_VAL};
    end else begin
      sy_reg <= sy_next;
    end
  end

  assign o_q = sy_reg.safe;

endmodule // cip_sync

// [design/cip_regs.sv]
// cip_regs: register file behind the serial port, straps, fault latch
// assumes strobes come from the protocol engine on the same clock
`timescale 1ns/10ps
module cip_regs
  import cip_pkg::*;
(
  input  wire logic        i_clk,             // system clock
  input  wire logic        i_rstn,            // async reset, active low
  input  wire logic        i_wr_stb,          // write one byte
  input  wire logic [7:0]  i_wr_idx,          // write index
  input  wire logic [7:0]  i_wr_data,         // write data
  input  wire logic        i_rd_req,          // byte being read now
  input  wire logic [7:0]  i_rd_idx,          // read index
  output logic      [7:0]  o_rd_data,         // read data
  input  wire logic        i_write_cmd,       // write transfer addressed
  input  wire logic        i_source_select,   // strap pin
  input  wire logic        i_host_port_level, // strap pin
  input  wire logic [7:0]  i_charger_status,  // status, same clock
  input  wire logic [6:0]  i_fault_now,       // present faults
  output logic             o_input_highz_enable,     // index 0 field
  output logic      [3:0]  o_input_voltage_floor,    // index 0 field
  output logic      [2:0]  o_input_current_cap,      // index 0 field
  output logic             o_reverse_boost_enable,   // index 1 field
  output logic             o_charging_enable,        // after override
  output logic      [2:0]  o_minimum_system_voltage, // index 1 field
  output logic             o_boost_current_cap,      // index 1 field
  output logic             o_watchdog_kick,   // one-cycle pulse
  output logic             o_default_mode,    // autonomous mode
  output logic      [47:0] o_config_regs      // indices 7..2
);

  typedef struct packed {
    logic [7:0][7:0] rw;
    logic [6:0]      flt;
    logic            host;
    logic [1:0]      strap_wait;
    logic [2:0]      cap_dflt;
    logic            kick;
    logic            chg_eff;
  } cip_regs_t;

  localparam cip_regs_t REGS_RST = '{rw: RST_RW, chg_eff: 1'b1,
                                     default: '0};

  cip_regs_t  st_reg;
  cip_regs_t  st_next;
  logic [1:0] strap_s;

  cip_sync #(.WIDTH(2), .RST_VAL(2'h0)) u_strap_sync (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .i_d    ({i_source_select, i_host_port_level}),
    .o_q    (strap_s)
  );

  function automatic logic [2:0] strap_cap(input logic [1:0] s);
    if (!s[1]) begin
      return ICAP_SRC_LO;
    end
    return s[0] ? ICAP_USB_HI : ICAP_USB_LO;
  endfunction

  function automatic logic [7:0][7:0] defaults(input logic [2:0] cap);
    logic [7:0][7:0] d;
    d = RST_RW;
    d[IDX_INPUT_SRC[2:0]][ICAP_MSB:ICAP_LSB] = cap;
    return d;
  endfunction

  always_comb begin
    st_next = st_reg;
    st_next.kick = 1'b0;
    // straps are caught once the synchroniser has settled
    if (st_reg.strap_wait != 2'h3) begin
      st_next.strap_wait = st_reg.strap_wait + 2'h1;
      if (st_reg.strap_wait == 2'h2) begin
        st_next.cap_dflt = strap_cap(strap_s);
        st_next.rw = defaults(strap_cap(strap_s));
      end
    end
    if (i_write_cmd) begin
      st_next.host = 1'b1;
    end
    if (i_wr_stb && i_wr_idx <= IDX_RW_LAST) begin
      st_next.rw[i_wr_idx[2:0]] = i_wr_data;
      if (i_wr_idx == IDX_POWER_ON) begin
        st_next.rw[1][REGRST_BIT] = 1'b0;
        st_next.rw[1][WDKICK_BIT] = 1'b0;
        st_next.kick = i_wr_data[WDKICK_BIT];
        if (i_wr_data[REGRST_BIT]) begin
          st_next.rw = defaults(st_reg.cap_dflt);
        end
      end
    end
    // set wins: a fault present during the clearing read stays latched
    st_next.flt = st_reg.flt | i_fault_now;
    if (i_rd_req && i_rd_idx == IDX_FAULT) begin
      st_next.flt = i_fault_now;
    end
    st_next.chg_eff = st_next.rw[1][CHGEN_BIT] &
                      ~st_next.rw[1][RBOOST_BIT];
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg <= REGS_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    o_rd_data = READ_UNMAPPED;
    if (i_rd_idx <= IDX_RW_LAST) begin
      o_rd_data = st_reg.rw[i_rd_idx[2:0]];
    end else if (i_rd_idx == IDX_STATUS) begin
      o_rd_data = i_charger_status;
    end else if (i_rd_idx == IDX_FAULT) begin
      o_rd_data = {~st_reg.host, st_reg.flt | i_fault_now};
    end else if (i_rd_idx == IDX_LAST) begin
      o_rd_data = ID_CODE;
    end
  end

  assign o_input_highz_enable     = st_reg.rw[0][HIZ_BIT];
  assign o_input_voltage_floor    = st_reg.rw[0][VFLOOR_MSB:VFLOOR_LSB];
  assign o_input_current_cap      = st_reg.rw[0][ICAP_MSB:ICAP_LSB];
  assign o_reverse_boost_enable   = st_reg.rw[1][RBOOST_BIT];
  assign o_charging_enable        = st_reg.chg_eff;
  assign o_minimum_system_voltage = st_reg.rw[1][SYSMIN_MSB:SYSMIN_LSB];
  assign o_boost_current_cap      = st_reg.rw[1][BCAP_BIT];
  assign o_watchdog_kick          = st_reg.kick;
  assign o_default_mode           = ~st_reg.host;
  assign o_config_regs            = st_reg.rw[7:2];

  default clocking cb_regs @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  property p_boost_over_charge;
    o_reverse_boost_enable |-> !o_charging_enable;
  endproperty
  a_boost_over_charge: assert property (p_boost_over_charge)
    else $error("charging enabled while reverse boost set");

  property p_regrst_keeps_mode;
    (i_wr_stb && i_wr_idx == IDX_POWER_ON && i_wr_data[REGRST_BIT]
     && !i_write_cmd) |=> (st_reg.rw[1] == RST_POWER_ON) && $stable(st_reg.host);
  endproperty
  a_regrst_keeps_mode: assert property (p_regrst_keeps_mode)
    else $error("register reset wrong or mode changed");

  property p_fault_clears;
    (i_rd_req && i_rd_idx == IDX_FAULT && i_fault_now == 7'h00)
      |=> st_reg.flt == 7'h00;
  endproperty
  a_fault_clears: assert property (p_fault_clears)
    else $error("fault latch not cleared by read");

endmodule // cip_regs

// [tb/cip_master.sv]
// cip_master: behavioural two-wire bus master at 400 kbit/s
// assumes tb_top resolves both wires with pull-ups
`timescale 1ns/10ps
module cip_master (
  input  wire logic i_scl,     // resolved clock wire
  input  wire logic i_sda,     // resolved data wire
  output logic      o_scl_low, // pull clock low
  output logic      o_sda_low  // pull data low
);
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  // 1.4 us low plus 1.1 us high keeps the bit rate at 400 kbit/s
  task automatic bit_io(input logic b, output logic r);
    #700 o_sda_low = !b;
    #700 o_scl_low = 1'b0;
    wait (i_scl);
    #550 r = i_sda;
    #550 o_scl_low = 1'b1;
  endtask
  task automatic start();
    #700 o_sda_low = 1'b0;
    #700 o_scl_low = 1'b0;
    wait (i_scl);
    #600 o_sda_low = 1'b1;
    #600 o_scl_low = 1'b1;
  endtask
  task automatic stop();
    #650 o_sda_low = 1'b1;
    #650 o_scl_low = 1'b0;
    #600 o_sda_low = 1'b0;
    #650;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a,
                      output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, ak);
  endtask
endmodule // cip_master

// [tb/tb_top.sv]
// tb_top: self-checking bench for the charger serial port
// assumes cip_master as bus master; wires pulled up when released
`timescale 1ns/10ps
module tb_top;
  import cip_pkg::*;
  logic clk, rstn, m_scl, m_sda, scl_oe, sda_oe, busy, dm, kick;
  logic scl_o, sda_o, high_impedance_input_state, rbst, chg, bcap, sel, lvl;
  logic [3:0] vfl;
  logic [2:0] icap, smin;
  logic [47:0] cfg;
  logic [6:0] fnow;
  logic [7:0] q;
  logic ak;
  int n_fail = 0;
  int cmp_count = 0;
  int n_kick = 0;
  int n_str = 0;
  wire logic scl = !(m_scl || scl_oe);
  wire logic sda = !(m_sda || sda_oe);
  cip_master i_cip_master (.i_scl(scl), .i_sda(sda),
    .o_scl_low(m_scl), .o_sda_low(m_sda));
  cip_port i_cip_port (.i_clk(clk), .i_rstn(rstn), .i_scl(scl),
    .o_scl_out(scl_o), .o_scl_oe(scl_oe), .i_sda(sda), .o_sda_out(sda_o),
    .o_sda_oe(sda_oe), .i_source_select(sel),
    .i_host_port_level(lvl), .i_charger_status(8'h00),
    .i_fault_now(fnow), .o_input_highz_enable(high_impedance_input_state),
    .o_input_voltage_floor(vfl), .o_input_current_cap(icap),
    .o_reverse_boost_enable(rbst), .o_charging_enable(chg),
    .o_minimum_system_voltage(smin), .o_boost_current_cap(bcap),
    .o_watchdog_kick(kick), .o_default_mode(dm),
    .o_config_regs(cfg), .o_bus_busy(busy));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // pulse and stretch counters: both outputs stand for one cycle only
  always @(posedge clk) begin
    if (kick) begin
      n_kick++;
    end
    if (scl_oe) begin
      n_str++;
    end
  end
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic hdr(input logic [6:0] a, input logic [7:0] i);
    i_cip_master.start();
    i_cip_master.xfer({a, 1'b0}, 1'b1, q, ak);
    i_cip_master.xfer(i, 1'b1, q, ak);
  endtask
  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    hdr(TARGET_ADDR, i);
    i_cip_master.xfer(d, 1'b1, q, ak);
    i_cip_master.stop();
  endtask
  // read one byte at the index the port holds now
  task automatic rcur();
    i_cip_master.start();
    i_cip_master.xfer({TARGET_ADDR, 1'b1}, 1'b1, q, ak);
    i_cip_master.xfer(8'hFF, 1'b1, q, ak);
    i_cip_master.stop();
  endtask
  // two bytes, first acked by the master, second in q
  task automatic rpair(output logic [7:0] b0);
    i_cip_master.start();
    i_cip_master.xfer({TARGET_ADDR, 1'b1}, 1'b1, q, ak);
    i_cip_master.xfer(8'hFF, 1'b0, b0, ak);
    i_cip_master.xfer(8'hFF, 1'b1, q, ak);
    i_cip_master.stop();
  endtask
  task automatic rreg(input logic [7:0] i);
    hdr(TARGET_ADDR, i);
    rcur();
  endtask
  // reads only, so the port must stay in default mode
  task automatic t_reset_vals();
    logic [7:0] b0;
    chk({7'h00, dm}, 8'h01);
    chk(cfg[15:8], 8'h11);
    chk(cfg[7:0], 8'h60);
    chk({6'h00, sda_o, scl_o}, 8'h00);
    rpair(b0);
    chk(b0, 8'h37);
    chk(q, 8'h1B);
    chk({high_impedance_input_state, vfl, icap}, 8'h37);
    chk({2'h0, rbst, chg, smin, bcap}, 8'h1B);
    chk({7'h00, dm}, 8'h01);
    chk(n_str[7:0], 8'h02);
  endtask
  task automatic t_multi_write();
    logic [7:0] b0;
    hdr(TARGET_ADDR, IDX_INPUT_SRC);
    i_cip_master.xfer(8'hB2, 1'b1, q, ak);
    // single watchdog kick in the run, so no spacing to keep
    i_cip_master.xfer(8'h7A, 1'b1, q, ak);
    chk({7'h00, ak}, 8'h00);
    chk({7'h00, busy}, 8'h01);
    i_cip_master.stop();
    chk({7'h00, busy}, 8'h00);
    chk({7'h00, dm}, 8'h00);
    chk(n_kick[7:0], 8'h01);
    chk({high_impedance_input_state, vfl, icap}, 8'hB2);
    chk({2'h0, rbst, chg, smin, bcap}, 8'h2A);
    hdr(TARGET_ADDR, IDX_INPUT_SRC);
    rpair(b0);
    chk(b0, 8'hB2);
    chk(q, 8'h3A);
  endtask
  task automatic t_refusals();
    i_cip_master.start();
    i_cip_master.xfer(8'hD4, 1'b1, q, ak);
    i_cip_master.stop();
    chk({7'h00, ak}, 8'h01);
    hdr(TARGET_ADDR, 8'h0B);
    i_cip_master.stop();
    chk({7'h00, ak}, 8'h01);
    wreg(IDX_STATUS, 8'h55);
    chk({7'h00, ak}, 8'h01);
  endtask
  task automatic t_fault_latch();
    logic [7:0] b0;
    @(posedge clk);
    #1 fnow = 7'h01;
    repeat (20) @(posedge clk);
    #1 fnow = 7'h00;
    rreg(IDX_FAULT);
    chk(q, 8'h01);
    // index stays on the fault register; an ack must not continue
    rpair(b0);
    chk(b0, 8'h00);
    chk(q, 8'hFF);
  endtask
  task automatic t_reg_reset();
    wreg(IDX_POWER_ON, 8'h80);
    chk({high_impedance_input_state, vfl, icap}, 8'h37);
    chk({2'h0, rbst, chg, smin, bcap}, 8'h1B);
    rreg(IDX_POWER_ON);
    chk(q, 8'h1B);
    chk({7'h00, dm}, 8'h00);
  endtask
  // straps only change while reset is held
  task automatic strap_reset(input logic s, input logic l);
    @(posedge clk);
    #1 rstn = 1'b0;
    sel = s;
    lvl = l;
    repeat (6) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (10) @(posedge clk);
  endtask
  task automatic t_straps();
    strap_reset(1'b1, 1'b1);
    chk({5'h00, icap}, 8'h02);
    chk({7'h00, dm}, 8'h01);
    strap_reset(1'b1, 1'b0);
    chk({5'h00, icap}, 8'h00);
  endtask
  initial begin
    #800000;
    n_fail++;
    stop_test();
  end
  initial begin
    rstn = 1'b0;
    sel = 1'b0;
    lvl = 1'b0;
    fnow = 7'h00;
    repeat (6) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (10) @(posedge clk);
    t_reset_vals();
    t_multi_write();
    t_refusals();
    t_fault_latch();
    t_reg_reset();
    t_straps();
    stop_test();
  end
endmodule // tb_top
